/* File: sserx_peer.sv */
// Behavioural external serial peer for the receive and duplex block
`timescale 1ns/100ps
`default_nettype none

module sserx_peer (
  input  wire logic sck_pin_i,
  input  wire logic so_i,
  output logic      si_o,
  output logic      sck_ext_o
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic [7:0] cur;
  logic [7:0] cap;
  int         nbits = 8;
  int         bitn  = 0;
  int         edges = 0;
  int         s0;

  initial begin
    si_o = 1'b1;
    sck_ext_o = 1'b1;
  end

  // ----------------------------------------------------------------
  // Data out on leading edge, capture on trailing edge
  // ----------------------------------------------------------------
  always @(negedge sck_pin_i) begin
    edges++;
    if (bitn == 0) cur = (tx_q.size() > 0) ? tx_q.pop_front() : 8'($random);
    si_o = cur[bitn];
  end

  always @(posedge sck_pin_i) begin
    cap = {so_i, cap[7:1]};
    bitn++;
    if (bitn == nbits) begin
      rx_q.push_back(8'(cap >> (8 - nbits)));
      bitn = 0;
      s0 = edges;
      fork
        #300 if (edges == s0) si_o = ~si_o;
      join_none
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic clear();
    bitn = 0;
    tx_q.delete();
    rx_q.delete();
  endtask

  task automatic clock_bits(input int nb);
    #10;
    repeat (nb) begin
      sck_ext_o = 1'b0;
      #200;
      sck_ext_o = 1'b1;
      #200;
    end
  endtask
endmodule

`default_nettype wire

/* File: sserx_pkg.sv */
// Constants and types for the synchronous serial receive and duplex block
package sserx_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STAT   = 8'h04;
  localparam logic [2:0] ADR_DATA_H = 3'h1;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_ABORT   = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_EXT     = 4;
  localparam int CTRL_W8      = 5;
  localparam int CTRL_CNT_LO  = 8;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NWORDS = 8;
  localparam logic [2:0] BIT_LAST8 = 3'h7;
  localparam logic [2:0] BIT_LAST4 = 3'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCK_HALF_NS   = 200;
  localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SCK_HALF_M1 = 3'(SCK_HALF_CYC - 1);

  // ----------------------------------------------------------------
  // Modes and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_RX     = 2'b01,
    MODE_DUPLEX = 2'b10
  } sserx_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_WAIT  = 2'b10
  } sserx_state_t;

endpackage

/* File: sserx_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none

module sserx_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      q_o    <= '1;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* File: sserx_top.sv */
// Synchronous serial receive and full-duplex engine with Wishbone registers
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

module sserx_top
  import sserx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        si_i,
  output logic             so_o,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_n_o,
  output logic             transfer_done_irq_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_data(input logic [7:0] a);
    return a[7:5] == ADR_DATA_H;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sserx_state_t state_q, state_d;
  sserx_mode_t  mode_q;
  logic         transfer_run_bit_q, ext_q, w8_q, stop_q, pend_q;
  logic         transfer_active_flag_q, sck_prev_q;
  logic [2:0]   cnt_q, words_q, widx_q, bit_q, div_q, idx_h_q;
  logic [7:0]   rx_q, tx_q;
  logic [7:0]   shared_data_buffer_q [0:NWORDS-1];
  logic [1:0]   sync_w;

  sserx_sync #(.W(2)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sck_i, si_i}),
    .q_o   (sync_w)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire         sck_s     = sync_w[1];
  wire         si_s      = sync_w[0];
  wire         req       = cyc_i & stb_i & ~ack_o;
  wire         wr        = req & we_i;
  wire         rd        = req & ~we_i;
  wire         ctrl_wr   = wr & (adr_i == ADR_CTRL) & sel_i[0];
  wire         cnt_wr    = wr & (adr_i == ADR_CTRL) & sel_i[1];
  wire         data_wr   = wr & is_data(adr_i) & sel_i[0];
  wire         data_rd   = rd & is_data(adr_i);
  wire         abort_req = ctrl_wr & dat_i[CTRL_ABORT];
  wire         run_off   = ctrl_wr & ~dat_i[CTRL_RUN];
  wire sserx_mode_t new_mode = sserx_mode_t'(dat_i[CTRL_MODE_LO +: 2]);
  wire         mode_chg  = ctrl_wr & (new_mode != mode_q);

  // ----------------------------------------------------------------
  // Shift timing
  // ----------------------------------------------------------------
  wire         shifting  = state_q == ST_SHIFT;
  wire         duplex    = mode_q == MODE_DUPLEX;
  wire         wide      = duplex | w8_q;
  wire [2:0]   last_bit  = wide ? BIT_LAST8 : BIT_LAST4;
  wire         tick      = ~ext_q & (div_q == SCK_HALF_M1);
  wire         sck_line  = ext_q ? sck_s : sck_o;
  wire         lead      = shifting & (ext_q ? (sck_prev_q & ~sck_s) : (tick & sck_o));
  wire         trail     = shifting & (ext_q ? (~sck_prev_q & sck_s) : (tick & ~sck_o));
  wire [7:0]   rx_full   = {si_s, rx_q[7:1]};
  wire [7:0]   rx_word   = wide ? rx_full : {4'h0, rx_full[7:4]};
  wire         word_done = trail & (bit_q == last_bit);
  wire         burst_end = word_done & (widx_q == words_q);
  wire         overrun   = word_done & ext_q & ~duplex & pend_q;
  wire         hw_store  = word_done & ~overrun;
  wire         start     = (state_q == ST_IDLE) & transfer_run_bit_q & (mode_q != MODE_OFF);
  wire         idle_stop = shifting & stop_q & (bit_q == 3'h0) & sck_line & ~lead;
  wire         end_xfer  = abort_req | mode_chg | overrun | (word_done & stop_q) | idle_stop
                           | ((state_q == ST_WAIT) & stop_q);
  wire         rel_wait  = (~duplex & data_rd) | (duplex & data_wr);

  wire [31:0]  ctrl_rd = {21'h0, cnt_q, 2'h0, w8_q, ext_q, mode_q, 1'b0, transfer_run_bit_q};
  wire [31:0]  stat_rd = {30'h0, pend_q, transfer_active_flag_q};
  wire [31:0]  rd_mux  = (adr_i == ADR_CTRL) ? ctrl_rd :
                         (adr_i == ADR_STAT) ? stat_rd :
                         is_data(adr_i) ? {24'h0, shared_data_buffer_q[adr_i[4:2]]} : 32'h0000_0000;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (end_xfer) begin
      state_d = ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  if (start) state_d = ST_SHIFT;
        ST_SHIFT: if (burst_end & ~ext_q) state_d = ST_WAIT;
        ST_WAIT:  if (~pend_q) state_d = ST_SHIFT;
        default:  state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q                <= ST_IDLE;
      transfer_active_flag_q <= 1'b0;
      stop_q                 <= 1'b0;
    end else begin
      state_q                <= state_d;
      transfer_active_flag_q <= state_d != ST_IDLE;
      stop_q                 <= (state_d != ST_IDLE) & (stop_q | run_off);
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transfer_run_bit_q <= CTRL_RST[CTRL_RUN];
      mode_q             <= sserx_mode_t'(CTRL_RST[CTRL_MODE_LO +: 2]);
      ext_q              <= CTRL_RST[CTRL_EXT];
      w8_q               <= CTRL_RST[CTRL_W8];
      cnt_q              <= CTRL_RST[CTRL_CNT_LO +: 3];
    end else begin
      if (ctrl_wr) begin
        transfer_run_bit_q <= dat_i[CTRL_RUN] & ~dat_i[CTRL_ABORT];
        mode_q             <= new_mode;
        ext_q              <= dat_i[CTRL_EXT];
        w8_q               <= dat_i[CTRL_W8];
      end else if (overrun) begin
        transfer_run_bit_q <= 1'b0;
      end
      if (cnt_wr) cnt_q <= dat_i[CTRL_CNT_LO +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      words_q <= 3'h0;
      widx_q  <= 3'h0;
      bit_q   <= 3'h0;
      div_q   <= 3'h0;
      rx_q    <= 8'h00;
      tx_q    <= 8'h00;
      idx_h_q <= 3'h0;
    end else begin
      if (start | (state_q == ST_WAIT)) words_q <= cnt_q;
      if (start | end_xfer) begin
        widx_q <= 3'h0;
        bit_q  <= 3'h0;
      end else if (trail) begin
        bit_q  <= word_done ? 3'h0 : bit_q + 3'h1;
        if (word_done) widx_q <= burst_end ? 3'h0 : widx_q + 3'h1;
      end
      div_q <= (~shifting | tick) ? 3'h0 : div_q + 3'h1;
      if (trail) rx_q <= rx_full;
      if (lead) tx_q <= (bit_q == 3'h0) ? shared_data_buffer_q[widx_q] >> 1 : tx_q >> 1;
      if (hw_store) idx_h_q <= widx_q;
    end
  end

  // ----------------------------------------------------------------
  // Pending data and wait release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= 1'b0;
    end else if (burst_end & ~overrun) begin
      pend_q <= 1'b1;
    end else if (rel_wait | start) begin
      pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i | mode_chg) begin
      for (int i = 0; i < NWORDS; i++) begin
        shared_data_buffer_q[i] <= 8'h00;
      end
    end else begin
      if (data_wr) shared_data_buffer_q[adr_i[4:2]] <= dat_i[7:0];
      if (hw_store) shared_data_buffer_q[widx_q] <= rx_word;
    end
  end

  // ----------------------------------------------------------------
  // Pins, interrupt and bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_o                <= 1'b1;
      sck_o               <= 1'b1;
      sck_oe_n_o          <= 1'b1;
      sck_prev_q          <= 1'b1;
      transfer_done_irq_o <= 1'b0;
      ack_o               <= 1'b0;
      dat_o               <= 32'h0000_0000;
    end else begin
      if (lead & duplex) begin
        so_o <= (bit_q == 3'h0) ? shared_data_buffer_q[widx_q][0] : tx_q[0];
      end
      sck_o               <= shifting ? (sck_o ^ tick) : 1'b1;
      sck_oe_n_o          <= ~((mode_q != MODE_OFF) & ~ext_q);
      sck_prev_q          <= sck_s;
      transfer_done_irq_o <= burst_end & ~overrun;
      ack_o               <= req;
      dat_o               <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_abort_stops;
    @(posedge clk_i) disable iff (rst_i)
    abort_req |=> !transfer_active_flag_q && state_q == ST_IDLE;
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("abort left block active");

  property p_start_active;
    @(posedge clk_i) disable iff (rst_i)
    start && !end_xfer |=> transfer_active_flag_q && state_q == ST_SHIFT;
  endproperty
  a_start_active: assert property (p_start_active) else $error("start did not set active");

  property p_irq_burst;
    @(posedge clk_i) disable iff (rst_i)
    burst_end && !overrun |=> transfer_done_irq_o ##1 !transfer_done_irq_o;
  endproperty
  a_irq_burst: assert property (p_irq_burst) else $error("done irq not a pulse");

  property p_wait_holds;
    @(posedge clk_i) disable iff (rst_i)
    state_q == ST_WAIT && pend_q && !end_xfer |=> state_q == ST_WAIT && sck_o;
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("wait released early");

  property p_wait_release;
    @(posedge clk_i) disable iff (rst_i)
    state_q == ST_WAIT && rel_wait && !stop_q && !end_xfer
      |-> ##2 (state_q == ST_SHIFT || state_q == ST_IDLE);
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("wait not released");

  property p_overrun_stop;
    @(posedge clk_i) disable iff (rst_i)
    overrun |=> !transfer_active_flag_q && !transfer_run_bit_q;
  endproperty
  a_overrun_stop: assert property (p_overrun_stop) else $error("overrun kept receiving");

  property p_upper_zero;
    @(posedge clk_i) disable iff (rst_i)
    hw_store && !wide |=> shared_data_buffer_q[idx_h_q][7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("narrow word upper bits set");

  property p_so_stable;
    @(posedge clk_i) disable iff (rst_i)
    !lead |=> $stable(so_o);
  endproperty
  a_so_stable: assert property (p_so_stable) else $error("output moved off leading edge");

  property p_stop_end;
    @(posedge clk_i) disable iff (rst_i)
    word_done && stop_q |=> !transfer_active_flag_q ##0 $past(hw_store);
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop did not finish word");

  property p_mode_clear;
    @(posedge clk_i) disable iff (rst_i)
    mode_chg |=> shared_data_buffer_q[0] == 8'h00 && !transfer_active_flag_q;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("mode change kept buffer");

  property p_lsb_first;
    @(posedge clk_i) disable iff (rst_i)
    trail |=> rx_q[7] == $past(si_s);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("input bit not shifted in");

  c_rx_burst:   cover property (@(posedge clk_i) disable iff (rst_i) burst_end && !duplex);
  c_duplex_wait: cover property (@(posedge clk_i) disable iff (rst_i)
                                state_q == ST_WAIT && duplex);
  c_overrun:    cover property (@(posedge clk_i) disable iff (rst_i) overrun);

endmodule

`default_nettype wire

/* File: sserx_top_tb.sv */
// Self-checking testbench for the serial receive and duplex block
`timescale 1ns/100ps
`default_nettype none

module sserx_top_tb
  import sserx_pkg::*;
;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic        ack_o, so_o, sck_o, sck_oe_n_o, transfer_done_irq_o;
  logic        si_w, peer_sck, sck_pin;
  int          mismatches, samples_checked, seed, nw, n;
  logic [7:0]  b;
  logic [7:0]  t[8];
  logic [7:0]  r[8];
  logic [7:0]  e[$];

  assign sck_pin = sck_oe_n_o ? peer_sck : sck_o;

  sserx_top dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .si_i(si_w), .so_o(so_o), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_n_o(sck_oe_n_o), .transfer_done_irq_o(transfer_done_irq_o)
  );

  sserx_peer peer_u (
    .sck_pin_i(sck_pin), .so_i(so_o), .si_o(si_w), .sck_ext_o(peer_sck)
  );

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] rq);
    int k;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 100);
    rq = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    chk("ack", 1, ack_o);
  endtask

  function automatic logic [31:0] ctrl(input logic run, input logic abt, input logic [1:0] md,
                                       input logic ext, input logic w8, input logic [2:0] c);
    ctrl = 32'h0;
    ctrl[CTRL_RUN] = run;
    ctrl[CTRL_ABORT] = abt;
    ctrl[CTRL_MODE_LO +: 2] = md;
    ctrl[CTRL_EXT] = ext;
    ctrl[CTRL_W8] = w8;
    ctrl[CTRL_CNT_LO +: 3] = c;
  endfunction

  function automatic logic [7:0] da(input int i);
    da = 8'h20 + 8'(4 * i);
  endfunction

  task automatic wait_irq();
    n = 0;
    while (transfer_done_irq_o !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    chk("done irq", 1, transfer_done_irq_o);
  endtask

  task automatic stall();
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (sck_o !== 1'b1) n++;
    end
    chk("sck held", 0, 32'(n));
  endtask

  task automatic wait_idle();
    q = 32'h1;
    for (int i = 0; i < 200 && q[0] !== 1'b0; i++) wb(1'b0, ADR_STAT, 32'h0, q);
    chk("active clear", 0, 32'(q[0]));
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2_000_000;
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    seed = 92643;
    mismatches = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    peer_u.clear();
    chk("so idle", 1, so_o);
    chk("sck idle", 1, sck_o);
    wb(1'b0, ADR_CTRL, 32'h0, q);
    chk("ctrl reset", CTRL_RST, q);
    wb(1'b1, 8'h14, 32'hFFFF_FFFF, q);
    wb(1'b0, 8'h14, 32'h0, q);
    chk("unmapped", 0, q);
    $display("test reset done");
    for (int w = 1; w >= 0; w--) begin
      peer_u.clear();
      peer_u.nbits = w ? 8 : 4;
      nw = 1 + ($random(seed) & 7);
      e.delete();
      for (int i = 0; i <= nw; i++) begin
        b = 8'($random(seed));
        peer_u.tx_q.push_back(b);
        e.push_back(w ? b : {4'h0, b[3:0]});
      end
      wb(1'b1, ADR_CTRL, ctrl(1, 0, MODE_RX, 0, 1'(w), 3'(nw - 1)), q);
      wait_irq();
      wb(1'b0, ADR_STAT, 32'h0, q);
      chk("stat in wait", 32'h3, q);
      stall();
      wb(1'b0, da(7), 32'h0, q);
      for (int i = 0; i < nw; i++) begin
        wb(1'b0, da(i), 32'h0, q);
        chk("rx word", 32'(e[i]), q);
      end
      wb(1'b1, ADR_CTRL, ctrl(0, 0, MODE_RX, 0, 1'(w), 3'(nw - 1)), q);
      wait_idle();
      wb(1'b0, da(0), 32'h0, q);
      chk("word in flight", 32'(e[nw]), q);
      $display("test rx width %0d done", w ? 8 : 4);
    end
    peer_u.clear();
    peer_u.nbits = 8;
    nw = 1 + ($unsigned($random(seed)) % 7);
    wb(1'b1, ADR_CTRL, ctrl(0, 0, MODE_DUPLEX, 0, 1, 3'(nw - 1)), q);
    wb(1'b0, da(0), 32'h0, q);
    chk("buffer cleared", 0, q);
    for (int i = 0; i < nw; i++) begin
      t[i] = 8'($random(seed));
      r[i] = 8'($random(seed));
      peer_u.tx_q.push_back(r[i]);
      wb(1'b1, da(i), 32'(t[i]), q);
    end
    wb(1'b1, ADR_CTRL, ctrl(1, 0, MODE_DUPLEX, 0, 1, 3'(nw - 1)), q);
    wait_irq();
    stall();
    wb(1'b1, ADR_CTRL, ctrl(1, 0, MODE_DUPLEX, 0, 1, 3'h0), q);
    chk("so holds", 32'(t[nw - 1][7]), 32'(so_o));
    for (int i = 0; i < nw; i++) begin
      wb(1'b0, da(i), 32'h0, q);
      chk("duplex rx", 32'(r[i]), q);
      chk("duplex tx", 32'(t[i]), 32'(peer_u.rx_q.pop_front()));
    end
    wb(1'b1, da(7), 32'h0, q);
    n = 0;
    while (sck_o === 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    chk("sck resumed", 0, sck_o);
    wait_irq();
    wb(1'b1, ADR_CTRL, ctrl(0, 1, MODE_DUPLEX, 0, 1, 3'(nw - 1)), q);
    wb(1'b0, ADR_STAT, 32'h0, q);
    chk("abort", 0, 32'(q[0]));
    $display("test duplex done");
    peer_u.clear();
    wb(1'b1, ADR_CTRL, ctrl(0, 0, MODE_RX, 1, 1, 3'h0), q);
    for (int i = 0; i < 2; i++) begin
      t[i] = 8'($random(seed));
      peer_u.tx_q.push_back(t[i]);
    end
    wb(1'b1, ADR_CTRL, ctrl(1, 0, MODE_RX, 1, 1, 3'h0), q);
    fork
      peer_u.clock_bits(8);
    join_none
    wait_irq();
    repeat (8) @(posedge clk_i);
    peer_u.clock_bits(8);
    repeat (10) @(posedge clk_i);
    wb(1'b0, ADR_STAT, 32'h0, q);
    chk("overrun stop", 0, 32'(q[0]));
    wb(1'b0, da(0), 32'h0, q);
    chk("first word kept", 32'(t[0]), q);
    $display("test external overrun done");
    peer_u.clear();
    wb(1'b1, ADR_CTRL, ctrl(0, 0, MODE_DUPLEX, 1, 1, 3'h0), q);
    b = 8'($random(seed));
    peer_u.tx_q.push_back(b);
    wb(1'b1, da(0), 32'(t[0]), q);
    wb(1'b1, ADR_CTRL, ctrl(1, 0, MODE_DUPLEX, 1, 1, 3'h0), q);
    fork
      peer_u.clock_bits(8);
    join_none
    wait_irq();
    wb(1'b0, da(0), 32'h0, q);
    chk("ext duplex rx", 32'(b), q);
    wb(1'b1, da(0), 32'(t[1]), q);
    repeat (8) @(posedge clk_i);
    peer_u.clock_bits(8);
    repeat (4) @(posedge clk_i);
    chk("ext duplex tx0", 32'(t[0]), 32'(peer_u.rx_q.pop_front()));
    chk("ext duplex tx1", 32'(t[1]), 32'(peer_u.rx_q.pop_front()));
    $display("test external duplex done");
    give_verdict();
  end
endmodule

`default_nettype wire
